// ### src/tkac_regs.vh
`ifndef TKAC_REGS_VH
`define TKAC_REGS_VH
// register offsets on the sfr port
`define TKAC_OFS_TOUCH_CTRL   8'had
`define TKAC_OFS_ADC_CFG      8'hae
`define TKAC_OFS_P0_AEN       8'haf
`define TKAC_OFS_P3_DATA      8'hb0
`define TKAC_OFS_TOUCH_HIGH   8'haa
`define TKAC_OFS_TOUCH_LOW    8'hac
`define TKAC_OFS_TOUCH_START  8'hc0
`define TKAC_OFS_IRQ_STATUS   8'hc1
`define TKAC_OFS_IRQ_MASK     8'hc2
// field positions
`define TKAC_BIT_PD           7
`define TKAC_BIT_DONE         6
`define TKAC_BIT_SLOW         5
`define TKAC_BIT_BG_FORCE     1
// reset values
`define TKAC_RST_TOUCH_CTRL   8'hc4
`define TKAC_RST_ADC_CFG      8'hf0
`define TKAC_RST_P0_AEN       8'h00
`define TKAC_RST_P3_DATA      8'hff
// touch conversion timing
`define TKAC_CONV_BASE        16'h0010
// adc channel codes
`define TKAC_CH_BANDGAP       4'hb
`endif

// ### src/tkac_control.v
// Summary of operation
// - power-down bit 7 resets 1, disables touch
// - done flag bit 6 read-only, resets 1
// - slow bit selects touch clock divide by two
// - two-bit voltage select, resets zero
// - three-bit conversion time, resets 100
// - four-bit adc channel select, resets 1111
// - bandgap force keeps generator on except stop
// - port0 analog enables for three pins
// - port3 data register resets to ones
// - twelve-bit touch count, high and low
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "tkac_regs.vh"
module tkac_control #(
    parameter CNT_W = 12
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire [7:0]       addr,
    input  wire [7:0]       wdata,
    input  wire             wr,
    input  wire             rd,
    output reg  [7:0]       rdata,
    input  wire             sleep_idle,
    input  wire             sleep_stop,
    input  wire             adc_busy,
    output reg              touch_sense_power_down,
    output reg              touch_clock_slow,
    output reg  [1:0]       touch_volt_select,
    output reg  [2:0]       touch_conv_time,
    output reg  [3:0]       adc_channel_select,
    output reg  [1:0]       adc_ref_select,
    output reg              bandgap_force_on,
    output reg              bandgap_enable,
    output reg  [2:0]       port0_analog_input_enable,
    output reg  [7:0]       port3_data,
    output reg              touch_conv_done,
    output reg              touch_clk_en,
    output reg              ref_invalid,
    output reg              irq
);
    // touch conversion state, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg [1:0]       state;
    reg [CNT_W-1:0] touch_count;
    reg [15:0]      run_left;
    reg             div_phase;
    reg [1:0]       irq_status;
    reg [1:0]       irq_mask;
    wire [7:0]      ctrl_rd;
    wire            start;
    wire            finish;
    wire [1:0]      events;

    // conversion length grows with the time field
    function [15:0] conv_len;
        input [2:0] t;
        begin
            conv_len = `TKAC_CONV_BASE << t;
        end
    endfunction

    assign ctrl_rd = {touch_sense_power_down, touch_conv_done, touch_clock_slow,
                      touch_volt_select, touch_conv_time};
    assign start   = wr && addr == `TKAC_OFS_TOUCH_START && !touch_sense_power_down
                     && state == ST_IDLE;
    assign finish  = state == ST_RUN && run_left == 16'h0000 && touch_clk_en;
    // event 0 touch done, event 1 bandgap with non-supply reference
    assign events  = {adc_channel_select == `TKAC_CH_BANDGAP && adc_ref_select != 2'b00,
                      finish};

    // reset images split into fields, so one header value drives them
    localparam [7:0] RST_CTRL = `TKAC_RST_TOUCH_CTRL;
    localparam [7:0] RST_ADC  = `TKAC_RST_ADC_CFG;
    localparam [7:0] RST_P0   = `TKAC_RST_P0_AEN;

    // per-register write strobes
    wire            wr_ctrl;
    wire            wr_adc;
    wire            wr_p0;
    wire            wr_p3;
    wire            wr_mask;
    wire            wr_status;
    wire [1:0]      clear_bits;
    reg  [7:0]      next_rdata;

    // address match, shared by the per-register write strobe decodes
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = a == ofs;
        end
    endfunction

    // write decode; reads decode separately below
    assign wr_ctrl    = wr && hit(addr, `TKAC_OFS_TOUCH_CTRL);
    assign wr_adc     = wr && hit(addr, `TKAC_OFS_ADC_CFG);
    assign wr_p0      = wr && hit(addr, `TKAC_OFS_P0_AEN);
    assign wr_p3      = wr && hit(addr, `TKAC_OFS_P3_DATA);
    assign wr_mask    = wr && hit(addr, `TKAC_OFS_IRQ_MASK);
    assign wr_status  = wr && hit(addr, `TKAC_OFS_IRQ_STATUS);
    // write-one-to-clear pattern for the sticky status
    assign clear_bits = wr_status ? wdata[1:0] : 2'b00;

    // touch control register; done bit 6 is never written
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            touch_sense_power_down <= RST_CTRL[`TKAC_BIT_PD];
            touch_clock_slow       <= RST_CTRL[`TKAC_BIT_SLOW];
            touch_volt_select      <= RST_CTRL[4:3];
            touch_conv_time        <= RST_CTRL[2:0];
        end
        else if (ce)
        begin
            if (wr_ctrl)
            begin
                touch_sense_power_down <= wdata[`TKAC_BIT_PD];
                touch_clock_slow       <= wdata[`TKAC_BIT_SLOW];
                touch_volt_select      <= wdata[4:3];
                touch_conv_time        <= wdata[2:0];
            end
        end
    end

    // adc channel and reference configuration
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_channel_select <= RST_ADC[7:4];
            adc_ref_select     <= RST_ADC[3:2];
            bandgap_force_on   <= RST_ADC[`TKAC_BIT_BG_FORCE];
        end
        else if (ce)
        begin
            if (wr_adc)
            begin
                adc_channel_select <= wdata[7:4];
                // any code is taken; misuse is only flagged, not blocked
                adc_ref_select     <= wdata[3:2];
                bandgap_force_on   <= wdata[`TKAC_BIT_BG_FORCE];
            end
        end
    end

    // port enables and port3 latch
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port0_analog_input_enable <= RST_P0[7:5];
            port3_data                <= `TKAC_RST_P3_DATA;
        end
        else if (ce)
        begin
            if (wr_p0)
            begin
                port0_analog_input_enable <= wdata[7:5];
            end
            if (wr_p3)
            begin
                port3_data <= wdata;
            end
        end
    end

    // slow mode gives every other tick to the touch engine
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_phase    <= 1'b0;
            touch_clk_en <= 1'b0;
        end
        else if (ce)
        begin
            div_phase    <= ~div_phase;
            touch_clk_en <= touch_clock_slow ? div_phase : 1'b1;
        end
    end

    // touch conversion sequencer
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state           <= ST_IDLE;
            touch_conv_done <= RST_CTRL[`TKAC_BIT_DONE];
            touch_count     <= {CNT_W{1'b0}};
            run_left        <= 16'h0000;
        end
        else if (ce)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state           <= ST_RUN;
                        touch_conv_done <= 1'b0;
                        touch_count     <= {CNT_W{1'b0}};
                        run_left        <= conv_len(touch_conv_time);
                    end
                end
                ST_RUN:
                begin
                    if (touch_sense_power_down)
                    begin
                        // power-down aborts, flag returns to finished
                        state           <= ST_IDLE;
                        touch_conv_done <= 1'b1;
                    end
                    else if (finish)
                    begin
                        state           <= ST_IDLE;
                        touch_conv_done <= 1'b1;
                    end
                    else if (touch_clk_en)
                    begin
                        run_left    <= run_left - 16'h0001;
                        touch_count <= touch_count + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // sticky status and mask; irq lags status by one cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status <= 2'b00;
            irq_mask   <= 2'b00;
            irq        <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_mask)
            begin
                irq_mask <= wdata[1:0];
            end
            // set wins, so an event in the clear cycle is not lost
            irq_status <= (irq_status & ~clear_bits) | events;
            irq        <= |(irq_status & irq_mask);
        end
    end

    // auto mode follows converter activity; force holds on outside stop
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bandgap_enable <= 1'b0;
            ref_invalid    <= 1'b0;
        end
        else if (ce)
        begin
            bandgap_enable <= !sleep_stop && (bandgap_force_on
                              || (!sleep_idle && adc_busy
                                  && adc_channel_select == `TKAC_CH_BANDGAP));
            ref_invalid    <= events[1];
        end
    end

    // read mux; unmapped addresses and idle cycles read zero
    always @*
    begin
        next_rdata = 8'h00;
        if (rd)
        begin
            case (addr)
                `TKAC_OFS_TOUCH_CTRL:  next_rdata = ctrl_rd;
                `TKAC_OFS_ADC_CFG:     next_rdata = {adc_channel_select, adc_ref_select, bandgap_force_on, 1'b0};
                `TKAC_OFS_P0_AEN:      next_rdata = {port0_analog_input_enable, 5'b00000};
                `TKAC_OFS_P3_DATA:     next_rdata = port3_data;
                `TKAC_OFS_TOUCH_HIGH:  next_rdata = {4'h0, touch_count[11:8]};
                `TKAC_OFS_TOUCH_LOW:   next_rdata = touch_count[7:0];
                `TKAC_OFS_IRQ_STATUS:  next_rdata = {6'b000000, irq_status};
                `TKAC_OFS_IRQ_MASK:    next_rdata = {6'b000000, irq_mask};
                default:               next_rdata = 8'h00;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (ce)
        begin
            rdata <= next_rdata;
        end
    end
endmodule // tkac_control

// ### testbench/tkac_control_asserts.sv
`timescale 1ns/1ns
`include "tkac_regs.vh"
module tkac_control_chk (
    input wire       clk,
    input wire       rst,
    input wire       ce,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       sleep_stop,
    input wire       adc_busy,
    input wire       touch_sense_power_down,
    input wire       touch_clock_slow,
    input wire [1:0] touch_volt_select,
    input wire [2:0] touch_conv_time,
    input wire [3:0] adc_channel_select,
    input wire       bandgap_force_on,
    input wire       bandgap_enable,
    input wire [2:0] port0_analog_input_enable,
    input wire [7:0] port3_data,
    input wire       touch_clk_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a write taken on the sfr port, and forced bandgap in stop
    sequence s_wr(a); ce && wr && addr == a; endsequence
    sequence s_stop; bandgap_force_on && sleep_stop && !adc_busy; endsequence
    property p_pd; s_wr(`TKAC_OFS_TOUCH_CTRL) |=> touch_sense_power_down == $past(wdata[7]); endproperty
    a_pd: assert property (p_pd) else $error("power down bit wrong");
    property p_slow; s_wr(`TKAC_OFS_TOUCH_CTRL) |=> touch_clock_slow == $past(wdata[5]); endproperty
    a_slow: assert property (p_slow) else $error("slow clock bit wrong");
    property p_fast_tick; ce && !touch_clock_slow |=> touch_clk_en; endproperty
    a_fast_tick: assert property (p_fast_tick) else $error("touch tick missing");
    property p_slow_tick; (ce && touch_clock_slow) [*2] |=> touch_clk_en != $past(touch_clk_en); endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow tick not halved");
    property p_volt; s_wr(`TKAC_OFS_TOUCH_CTRL) |=> touch_volt_select == $past(wdata[4:3]); endproperty
    a_volt: assert property (p_volt) else $error("voltage field wrong");
    property p_time; s_wr(`TKAC_OFS_TOUCH_CTRL) |=> touch_conv_time == $past(wdata[2:0]); endproperty
    a_time: assert property (p_time) else $error("conversion time wrong");
    property p_chan; s_wr(`TKAC_OFS_ADC_CFG) |=> adc_channel_select == $past(wdata[7:4]); endproperty
    a_chan: assert property (p_chan) else $error("channel field wrong");
    property p_p0; s_wr(`TKAC_OFS_P0_AEN) |=> port0_analog_input_enable == $past(wdata[7:5]); endproperty
    a_p0: assert property (p_p0) else $error("analog enable wrong");
    property p_p3; ce && rd && addr == `TKAC_OFS_P3_DATA |=> rdata == $past(port3_data); endproperty
    a_p3: assert property (p_p3) else $error("port3 read wrong");
    // stop must win over the force bit
    property p_bg; s_stop [*3] |-> !bandgap_enable; endproperty
    a_bg: assert property (p_bg) else $error("bandgap on in stop");
endmodule // tkac_control_chk

// ### testbench/test_tkac_control.sv
`timescale 1ns/1ns
`include "tkac_regs.vh"
module test_tkac_control;
    reg        clk, rst, ce, wr, rd, sleep_idle, sleep_stop, adc_busy;
    reg  [7:0] addr, wdata;
    wire [7:0] rdata, port3_data;
    wire       touch_sense_power_down, touch_clock_slow, bandgap_enable, touch_conv_done, ref_invalid, irq;
    wire       bandgap_force_on;
    wire [1:0] touch_volt_select, adc_ref_select;
    wire [2:0] touch_conv_time, port0_analog_input_enable;
    wire [3:0] adc_channel_select;
    integer    error_cnt, n_tests, cyc;
    localparam [7:0] r_ctl = `TKAC_OFS_TOUCH_CTRL, r_adc = `TKAC_OFS_ADC_CFG, r_p0 = `TKAC_OFS_P0_AEN;
    localparam [7:0] r_p3 = `TKAC_OFS_P3_DATA, r_st = `TKAC_OFS_IRQ_STATUS, r_msk = `TKAC_OFS_IRQ_MASK;
    tkac_control DUT (
        .clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .sleep_idle, .sleep_stop, .adc_busy,
        .touch_sense_power_down, .touch_clock_slow, .touch_volt_select, .touch_conv_time,
        .adc_channel_select, .adc_ref_select, .bandgap_force_on, .bandgap_enable,
        .port0_analog_input_enable, .port3_data, .touch_conv_done, .touch_clk_en(), .ref_invalid, .irq
    );
    task summarize;
    begin
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // one-cycle strobes, launched just after an edge
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    end
    endtask
    task t_ctrl;
    begin
        rd_chk(r_ctl, 8'hc4);
        chk({7'h00, touch_conv_done}, 8'h01);
        wr_reg(r_ctl, 8'h3f);
        rd_chk(r_ctl, 8'h7f);
        chk({7'h00, touch_clock_slow}, 8'h01);
        chk({6'h00, touch_volt_select}, 8'h03);
        chk({5'h00, touch_conv_time}, 8'h07);
    end
    endtask
    task t_adc;
    begin
        rd_chk(r_adc, 8'hf0);
        wr_reg(r_adc, 8'hb7);
        rd_chk(r_adc, 8'hb6);
        chk({4'h0, adc_channel_select}, 8'h0b);
        chk({6'h00, adc_ref_select}, 8'h01);
        chk({7'h00, bandgap_force_on}, 8'h01);
        chk({7'h00, ref_invalid}, 8'h01);
        @(posedge clk);
        sleep_idle <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, bandgap_enable}, 8'h01);
        @(posedge clk);
        sleep_stop <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, bandgap_enable}, 8'h00);
        @(posedge clk);
        sleep_idle <= 1'b0;
        sleep_stop <= 1'b0;
        wr_reg(r_adc, 8'hf0);
        wr_reg(r_st, 8'h03);
    end
    endtask
    task t_ports;
    begin
        rd_chk(r_p0, 8'h00);
        rd_chk(r_p3, 8'hff);
        wr_reg(r_p0, 8'hff);
        rd_chk(r_p0, 8'he0);
        wr_reg(r_p3, 8'h5a);
        rd_chk(r_p3, 8'h5a);
        rd_chk(8'h10, 8'h00);
    end
    endtask
    // masked first, so irq must stay low until the mask opens
    task t_touch;
    begin
        wr_reg(r_ctl, 8'h00);
        wr_reg(`TKAC_OFS_TOUCH_START, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, touch_conv_done}, 8'h00);
        wait (touch_conv_done === 1'b1);
        repeat (3) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        rd_chk(r_st, 8'h01);
        rd_chk(`TKAC_OFS_TOUCH_LOW, 8'h10);
        rd_chk(`TKAC_OFS_TOUCH_HIGH, 8'h00);
        wr_reg(r_msk, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h01);
        wr_reg(r_st, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, the run needs under a hundred cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    initial
    begin
        {rst, ce, wr, rd, sleep_idle, sleep_stop, adc_busy} = 7'b1100000;
        {addr, wdata} = 16'h0000;
        {error_cnt, n_tests, cyc} = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_ctrl;
        t_adc;
        t_ports;
        t_touch;
        summarize;
    end
endmodule // test_tkac_control
bind tkac_control tkac_control_chk u_chk (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .sleep_stop, .adc_busy, .touch_sense_power_down, .touch_clock_slow, .touch_volt_select,
    .touch_conv_time, .adc_channel_select, .bandgap_force_on, .bandgap_enable,
    .port0_analog_input_enable, .port3_data, .touch_clk_en);
